// *** inc/scr_pkg.sv ***
// Package with register map, field positions and reset values of the sensor register group.
package scr_pkg;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PRESS_W = 24;
  localparam int unsigned THS_W = 16;
  localparam int unsigned RATE_W = 3;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL_TWO = 7'h21;
  localparam logic [ADDR_W-1:0] ADDR_INT_PIN_CONTROL = 7'h22;
  localparam logic [ADDR_W-1:0] ADDR_INT_PIN_ROUTING = 7'h23;
  localparam logic [ADDR_W-1:0] ADDR_DIFF_INT_CONFIG = 7'h24;
  localparam logic [ADDR_W-1:0] ADDR_DIFF_INT_FLAGS = 7'h25;
  localparam logic [ADDR_W-1:0] ADDR_SAMPLE_STATUS = 7'h27;
  localparam logic [ADDR_W-1:0] ADDR_PRESSURE_OUT_LOW = 7'h28;
  localparam logic [ADDR_W-1:0] ADDR_PRESSURE_OUT_TOP = 7'h2A;
  localparam logic [ADDR_W-1:0] ADDR_TEMP_OUT_TOP = 7'h2C;
  localparam logic [DATA_W-1:0] RESET_BYTE = 8'h00;
  // Control register two fields.
  localparam int unsigned C2_REBOOT = 7;
  localparam int unsigned C2_QUEUE_ON = 6;
  localparam int unsigned C2_LEVEL_MARK_ON = 5;
  localparam int unsigned C2_RATE_DECIMATE_1HZ = 4;
  localparam int unsigned C2_I2C_OFF = 3;
  localparam int unsigned C2_SOFT_RESTART = 2;
  localparam int unsigned C2_AUTOZERO = 1;
  localparam int unsigned C2_ONE_SHOT = 0;
  // Interrupt pin control and routing fields.
  localparam int unsigned C3_ACTIVE_LOW = 7;
  localparam int unsigned C3_PAD_DRIVE_TYPE = 6;
  localparam logic [DATA_W-1:0] C3_WRITE_MASK = 8'hC3;
  localparam logic [DATA_W-1:0] C4_WRITE_MASK = 8'h0F;
  localparam int unsigned C4_ROUTE_QUEUE_EMPTY = 3;
  localparam int unsigned C4_ROUTE_LEVEL_MARK = 2;
  localparam int unsigned C4_ROUTE_QUEUE_FULL = 1;
  localparam int unsigned C4_ROUTE_SAMPLE_READY = 0;
  // Differential interrupt configuration and flag fields.
  localparam logic [DATA_W-1:0] CFG_WRITE_MASK = 8'h07;
  localparam int unsigned CFG_REQUEST_LATCH = 2;
  localparam int unsigned CFG_LOW_EVENT_ON = 1;
  localparam int unsigned CFG_HIGH_EVENT_ON = 0;
  localparam int unsigned FLG_ANY = 2;
  localparam int unsigned FLG_LOW = 1;
  localparam int unsigned FLG_HIGH = 0;
  // Sample status fields.
  localparam int unsigned ST_PRESS_OVERRUN = 5;
  localparam int unsigned ST_TEMP_OVERRUN = 4;
  localparam int unsigned ST_PRESS_AVAIL = 1;
  localparam int unsigned ST_TEMP_AVAIL = 0;
  // Threshold counts are 1/16 hPa, pressure counts are 1/4096 hPa: a factor of 256.
  localparam int unsigned THS_TO_PRESS_SHIFT = 8;
  localparam logic [RATE_W-1:0] RATE_ONE_SHOT = 3'h0;
  localparam logic [1:0] SEL_DATA = 2'h0;
  localparam logic [1:0] SEL_HIGH = 2'h1;
  localparam logic [1:0] SEL_LOW = 2'h2;
  localparam logic [1:0] SEL_LOW_OR_HIGH = 2'h3;
  typedef enum logic [1:0] {
    SCR_BOOT_IDLE = 2'b00,
    SCR_BOOT_WAIT = 2'b01,
    SCR_BOOT_DONE = 2'b10
  } scr_boot_t;
endpackage

// *** core/scr_regs.sv ***
// Control, interrupt and status register group of the barometric sensor.
// Functional notes
// - Reboot bit copies factory trim into trim registers, then clears itself.
// - Trim reload is applied one output-data-rate tick after the reboot bit is set.
// - Soft-restart plus reboot restores power-on configuration; soft-restart clears itself.
// - Queue enable, level-mark enable and 1 Hz decimation enable, all reset to zero.
// - Bit three zero keeps I2C enabled; one disables it leaving SPI only.
// - Autozero copies present pressure into reference; output becomes sensor minus reference.
// - With rate 000, one-shot starts one measurement and clears itself when done.
// - Polarity bit zero makes interrupt pin active high, one active low.
// - Pad drive bit zero gives push-pull, one gives open drain.
// - Source select: 00 data signals, 01 high, 10 low, 11 low or high.
// - Routing register selects queue empty, level mark, queue full, data ready; bits 7-4 zero.
// - Latch bit keeps interrupt flags latched until read; otherwise they follow events.
// - Low-event enable raises request when differential pressure is below threshold.
// - High-event enable raises request when differential pressure is above threshold.
// - Reading the interrupt flag register clears it.
// - Flag bit two any event, bit one low, bit zero high; upper bits zero.
// - Sample status updates every output-data-rate cycle regardless of hold setting.
// - Pressure-available sets on new pressure sample, clears on pressure top read.
// - Temperature-available sets on new temperature sample, clears on temperature top read.
// - Pressure overrun sets when new data meets uncleared flag; cleared by top read.
// - Temperature overrun sets when new data meets uncleared flag; cleared by top read.
// - Pressure output is 24-bit signed, measured minus reference, clipped at range limits.
// - Differential circuit enable gates all threshold event generation.
// - Threshold is 16-bit unsigned in 1/16 hPa steps.
`timescale 1ns/1ps
module scr_regs (
  // Clock and reset.
  input wire logic clock_in,
  input wire logic srst_in,
  // Register access from the serial front end.
  input wire logic [scr_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [scr_pkg::DATA_W-1:0] reg_wdata_in,
  output logic [scr_pkg::DATA_W-1:0] reg_rdata_out,
  output logic reg_hit_out,
  // Settings held in neighbouring registers.
  input wire logic [scr_pkg::RATE_W-1:0] rate_sel_in,
  input wire logic diff_circuit_on_in,
  input wire logic [scr_pkg::THS_W-1:0] threshold_in,
  input wire logic [scr_pkg::PRESS_W-1:0] reference_in,
  // Measurement core.
  input wire logic odr_tick_in,
  input wire logic press_sample_in,
  input wire logic temp_sample_in,
  input wire logic [scr_pkg::PRESS_W-1:0] press_raw_in,
  input wire logic queue_empty_in,
  input wire logic queue_level_mark_in,
  input wire logic queue_full_in,
  output logic measure_start_out,
  output logic trim_reload_out,
  output logic device_restart_out,
  output logic reference_load_out,
  output logic [scr_pkg::PRESS_W-1:0] reference_value_out,
  output logic [scr_pkg::PRESS_W-1:0] pressure_out,
  // Mode outputs.
  output logic queue_on_out,
  output logic level_mark_on_out,
  output logic rate_decimate_1hz_out,
  output logic i2c_off_out,
  // Interrupt pin.
  output logic irq_pin_out,
  output logic irq_pin_oe_out
);
  import scr_pkg::*;

  logic [DATA_W-1:0] control_two_reg;
  logic [DATA_W-1:0] int_pin_control_reg;
  logic [DATA_W-1:0] int_pin_routing_reg;
  logic [DATA_W-1:0] diff_int_config_reg;
  logic [DATA_W-1:0] diff_int_flags_reg;
  logic [DATA_W-1:0] sample_status_reg;
  logic [PRESS_W-1:0] pressure_out_reg;
  logic [PRESS_W-1:0] reference_value_reg;
  logic reference_load_reg, autozero_armed_reg, measure_start_reg;
  logic trim_reload_reg, device_restart_reg, one_shot_busy_reg;
  scr_boot_t boot_state_reg;
  scr_boot_t boot_state_next;

  logic wr_c2, rd_flags, rd_press_top, rd_temp_top, boot_finish, restart_now;
  logic [PRESS_W:0] diff_wide;
  logic [PRESS_W-1:0] diff_clip;
  logic signed [PRESS_W:0] ths_pos;
  logic signed [PRESS_W:0] ths_neg;
  logic high_event, low_event, any_event, data_signal, source_level;

  assign wr_c2 = reg_wr_in && (reg_addr_in == ADDR_CONTROL_TWO);
  assign rd_flags = reg_rd_in && (reg_addr_in == ADDR_DIFF_INT_FLAGS);
  assign rd_press_top = reg_rd_in && (reg_addr_in == ADDR_PRESSURE_OUT_TOP);
  assign rd_temp_top = reg_rd_in && (reg_addr_in == ADDR_TEMP_OUT_TOP);

  // Reboot sequence waits for a rate tick, then finishes.
  always_comb begin
    boot_state_next = boot_state_reg;
    unique case (boot_state_reg)
      SCR_BOOT_IDLE: begin
        if (control_two_reg[C2_REBOOT]) begin
          boot_state_next = SCR_BOOT_WAIT;
        end
      end
      SCR_BOOT_WAIT: begin
        if (odr_tick_in) begin
          boot_state_next = SCR_BOOT_DONE;
        end
      end
      SCR_BOOT_DONE: begin
        boot_state_next = SCR_BOOT_IDLE;
      end
      default: begin
        boot_state_next = SCR_BOOT_IDLE;
      end
    endcase
  end

  assign boot_finish = (boot_state_reg == SCR_BOOT_DONE);
  assign restart_now = boot_finish && control_two_reg[C2_SOFT_RESTART];

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      boot_state_reg <= SCR_BOOT_IDLE;
    end else begin
      boot_state_reg <= boot_state_next;
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      trim_reload_reg <= 1'b0;
      device_restart_reg <= 1'b0;
    end else begin
      trim_reload_reg <= boot_finish;
      device_restart_reg <= restart_now;
    end
  end

  // Control register two with self-clearing reboot, restart and one-shot bits.
  always_ff @(posedge clock_in) begin
    if (srst_in || restart_now) begin
      control_two_reg <= RESET_BYTE;
    end else begin
      if (wr_c2) begin
        control_two_reg <= reg_wdata_in;
      end
      if (boot_finish) begin
        control_two_reg[C2_REBOOT] <= 1'b0;
      end
      if (one_shot_busy_reg && press_sample_in) begin
        control_two_reg[C2_ONE_SHOT] <= 1'b0;
      end
    end
  end

  // One-shot start pulse, only in the one-shot rate setting.
  always_ff @(posedge clock_in) begin
    if (srst_in || restart_now) begin
      one_shot_busy_reg <= 1'b0;
      measure_start_reg <= 1'b0;
    end else begin
      measure_start_reg <= 1'b0;
      if (one_shot_busy_reg) begin
        if (press_sample_in) begin
          one_shot_busy_reg <= 1'b0;
        end
      end else if (control_two_reg[C2_ONE_SHOT] && rate_sel_in == RATE_ONE_SHOT) begin
        one_shot_busy_reg <= 1'b1;
        measure_start_reg <= 1'b1;
      end
    end
  end

  // Pin control and routing registers; reserved bits are never stored.
  always_ff @(posedge clock_in) begin
    if (srst_in || restart_now) begin
      int_pin_control_reg <= RESET_BYTE;
      int_pin_routing_reg <= RESET_BYTE;
      diff_int_config_reg <= RESET_BYTE;
    end else if (reg_wr_in) begin
      if (reg_addr_in == ADDR_INT_PIN_CONTROL) begin
        int_pin_control_reg <= reg_wdata_in & C3_WRITE_MASK;
      end
      if (reg_addr_in == ADDR_INT_PIN_ROUTING) begin
        int_pin_routing_reg <= reg_wdata_in & C4_WRITE_MASK;
      end
      if (reg_addr_in == ADDR_DIFF_INT_CONFIG) begin
        diff_int_config_reg <= reg_wdata_in & CFG_WRITE_MASK;
      end
    end
  end

  // Measured minus reference, clipped to the signed 24-bit range.
  always_comb begin
    diff_wide = {press_raw_in[PRESS_W-1], press_raw_in} - {reference_in[PRESS_W-1], reference_in};
    diff_clip = diff_wide[PRESS_W-1:0];
    if (diff_wide[PRESS_W] != diff_wide[PRESS_W-1]) begin
      diff_clip = {diff_wide[PRESS_W], {(PRESS_W-1){~diff_wide[PRESS_W]}}};
    end
  end

  // Autozero captures the raw value at the first sample after the bit rises.
  always_ff @(posedge clock_in) begin
    if (srst_in || restart_now) begin
      autozero_armed_reg <= 1'b0;
      reference_load_reg <= 1'b0;
      reference_value_reg <= '0;
    end else begin
      reference_load_reg <= 1'b0;
      if (!control_two_reg[C2_AUTOZERO]) begin
        autozero_armed_reg <= 1'b1;
      end else if (autozero_armed_reg && press_sample_in) begin
        autozero_armed_reg <= 1'b0;
        reference_load_reg <= 1'b1;
        reference_value_reg <= press_raw_in;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in || restart_now) begin
      pressure_out_reg <= '0;
    end else if (press_sample_in) begin
      if (control_two_reg[C2_AUTOZERO] && autozero_armed_reg) begin
        pressure_out_reg <= '0;
      end else begin
        pressure_out_reg <= diff_clip;
      end
    end
  end

  // Threshold compare on the differential value.
  assign ths_pos = $signed({{(PRESS_W+1-THS_W-THS_TO_PRESS_SHIFT){1'b0}}, threshold_in,
                            {THS_TO_PRESS_SHIFT{1'b0}}});
  assign ths_neg = -ths_pos;
  assign high_event = diff_circuit_on_in && press_sample_in && diff_int_config_reg[CFG_HIGH_EVENT_ON]
                      && ($signed(diff_wide) > ths_pos);
  assign low_event = diff_circuit_on_in && press_sample_in && diff_int_config_reg[CFG_LOW_EVENT_ON]
                     && ($signed(diff_wide) < ths_neg);
  assign any_event = high_event || low_event;

  // Event flags: latched until read, or refreshed on every pressure sample; a set beats a read.
  always_ff @(posedge clock_in) begin
    if (srst_in || restart_now) begin
      diff_int_flags_reg <= RESET_BYTE;
    end else if (diff_int_config_reg[CFG_REQUEST_LATCH]) begin
      if (rd_flags) begin
        diff_int_flags_reg <= RESET_BYTE;
      end
      if (any_event) begin
        diff_int_flags_reg[FLG_ANY] <= 1'b1;
      end
      if (high_event) begin
        diff_int_flags_reg[FLG_HIGH] <= 1'b1;
      end
      if (low_event) begin
        diff_int_flags_reg[FLG_LOW] <= 1'b1;
      end
    end else if (press_sample_in) begin
      diff_int_flags_reg <= RESET_BYTE;
      diff_int_flags_reg[FLG_ANY] <= any_event;
      diff_int_flags_reg[FLG_HIGH] <= high_event;
      diff_int_flags_reg[FLG_LOW] <= low_event;
    end else if (rd_flags) begin
      diff_int_flags_reg <= RESET_BYTE;
    end
  end

  // Sample status; a new sample wins over a read in the same cycle.
  always_ff @(posedge clock_in) begin
    if (srst_in || restart_now) begin
      sample_status_reg <= RESET_BYTE;
    end else begin
      if (rd_press_top) begin
        sample_status_reg[ST_PRESS_AVAIL] <= 1'b0;
        sample_status_reg[ST_PRESS_OVERRUN] <= 1'b0;
      end
      if (rd_temp_top) begin
        sample_status_reg[ST_TEMP_AVAIL] <= 1'b0;
        sample_status_reg[ST_TEMP_OVERRUN] <= 1'b0;
      end
      if (press_sample_in) begin
        sample_status_reg[ST_PRESS_AVAIL] <= 1'b1;
        if (sample_status_reg[ST_PRESS_AVAIL]) begin
          sample_status_reg[ST_PRESS_OVERRUN] <= 1'b1;
        end
      end
      if (temp_sample_in) begin
        sample_status_reg[ST_TEMP_AVAIL] <= 1'b1;
        if (sample_status_reg[ST_TEMP_AVAIL]) begin
          sample_status_reg[ST_TEMP_OVERRUN] <= 1'b1;
        end
      end
    end
  end

  // Read multiplexer; unmapped addresses read zero and report no hit.
  always_comb begin
    reg_rdata_out = RESET_BYTE;
    reg_hit_out = 1'b1;
    unique case (reg_addr_in)
      ADDR_CONTROL_TWO: reg_rdata_out = control_two_reg;
      ADDR_INT_PIN_CONTROL: reg_rdata_out = int_pin_control_reg;
      ADDR_INT_PIN_ROUTING: reg_rdata_out = int_pin_routing_reg;
      ADDR_DIFF_INT_CONFIG: reg_rdata_out = diff_int_config_reg;
      ADDR_DIFF_INT_FLAGS: reg_rdata_out = diff_int_flags_reg;
      ADDR_SAMPLE_STATUS: reg_rdata_out = sample_status_reg;
      ADDR_PRESSURE_OUT_LOW: reg_rdata_out = pressure_out_reg[DATA_W-1:0];
      default: reg_hit_out = 1'b0;
    endcase
  end

  // Interrupt pin source, polarity and drive.
  assign data_signal = (int_pin_routing_reg[C4_ROUTE_QUEUE_EMPTY] && queue_empty_in)
    || (int_pin_routing_reg[C4_ROUTE_LEVEL_MARK] && queue_level_mark_in)
    || (int_pin_routing_reg[C4_ROUTE_QUEUE_FULL] && queue_full_in)
    || (int_pin_routing_reg[C4_ROUTE_SAMPLE_READY] && sample_status_reg[ST_PRESS_AVAIL]);

  always_comb begin
    unique case (int_pin_control_reg[1:0])
      SEL_DATA: source_level = data_signal;
      SEL_HIGH: source_level = diff_int_flags_reg[FLG_HIGH];
      SEL_LOW: source_level = diff_int_flags_reg[FLG_LOW];
      SEL_LOW_OR_HIGH: source_level = diff_int_flags_reg[FLG_HIGH] || diff_int_flags_reg[FLG_LOW];
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      irq_pin_out <= 1'b0;
      irq_pin_oe_out <= 1'b1;
    end else begin
      irq_pin_out <= source_level ^ int_pin_control_reg[C3_ACTIVE_LOW];
      if (int_pin_control_reg[C3_PAD_DRIVE_TYPE]) begin
        irq_pin_oe_out <= source_level;
      end else begin
        irq_pin_oe_out <= 1'b1;
      end
    end
  end

  assign measure_start_out = measure_start_reg;
  assign trim_reload_out = trim_reload_reg;
  assign device_restart_out = device_restart_reg;
  assign reference_load_out = reference_load_reg;
  assign reference_value_out = reference_value_reg;
  assign pressure_out = pressure_out_reg;
  assign queue_on_out = control_two_reg[C2_QUEUE_ON];
  assign level_mark_on_out = control_two_reg[C2_LEVEL_MARK_ON];
  assign rate_decimate_1hz_out = control_two_reg[C2_RATE_DECIMATE_1HZ];
  assign i2c_off_out = control_two_reg[C2_I2C_OFF];

  // Checks.
  sequence boot_armed_s;
    boot_state_reg == SCR_BOOT_WAIT && odr_tick_in;
  endsequence
  sequence boot_done_s;
    ##2 trim_reload_out && !control_two_reg[C2_REBOOT];
  endsequence
  AST_BOOT_AFTER_TICK: assert property (@(posedge clock_in) disable iff (srst_in)
    boot_armed_s |-> boot_done_s)
    else $error("trim reload did not follow the rate tick");
  AST_RELOAD_NEEDS_TICK: assert property (@(posedge clock_in) disable iff (srst_in)
    trim_reload_out |-> $past(boot_state_reg, 2) == SCR_BOOT_WAIT)
    else $error("trim reload without a waiting reboot");
  AST_RESTART_CLEARS: assert property (@(posedge clock_in) disable iff (srst_in)
    restart_now |=> control_two_reg == RESET_BYTE && int_pin_control_reg == RESET_BYTE)
    else $error("restart left configuration set");
  AST_ONE_SHOT_RATE: assert property (@(posedge clock_in) disable iff (srst_in)
    measure_start_out |-> $past(rate_sel_in) == RATE_ONE_SHOT)
    else $error("one-shot start outside one-shot rate");
  AST_FLAGS_READ_CLEAR: assert property (@(posedge clock_in) disable iff (srst_in)
    rd_flags && !any_event && !(press_sample_in && !diff_int_config_reg[CFG_REQUEST_LATCH])
    |=> diff_int_flags_reg == RESET_BYTE)
    else $error("flag read did not clear");
  AST_HIGH_LATCHED: assert property (@(posedge clock_in) disable iff (srst_in)
    high_event |=> diff_int_flags_reg[FLG_HIGH] && diff_int_flags_reg[FLG_ANY])
    else $error("high event not flagged");
  AST_NO_EVENT_WHEN_OFF: assert property (@(posedge clock_in) disable iff (srst_in)
    !diff_circuit_on_in |-> !high_event && !low_event)
    else $error("event with circuit off");
  AST_PRESS_OVERRUN: assert property (@(posedge clock_in) disable iff (srst_in)
    press_sample_in && sample_status_reg[ST_PRESS_AVAIL] |=> sample_status_reg[ST_PRESS_OVERRUN])
    else $error("pressure overrun missed");
  AST_PRESS_AVAIL_CLEAR: assert property (@(posedge clock_in) disable iff (srst_in)
    rd_press_top && !press_sample_in |=> !sample_status_reg[ST_PRESS_AVAIL])
    else $error("pressure available not cleared by top read");
  AST_TEMP_AVAIL_SET: assert property (@(posedge clock_in) disable iff (srst_in)
    temp_sample_in |=> sample_status_reg[ST_TEMP_AVAIL])
    else $error("temperature available not set");
  AST_ROUTING_RESERVED: assert property (@(posedge clock_in) disable iff (srst_in)
    reg_wr_in && reg_addr_in == ADDR_INT_PIN_ROUTING |=> int_pin_routing_reg[7:4] == 4'h0)
    else $error("routing reserved bits stored");
  AST_PIN_POLARITY: assert property (@(posedge clock_in) disable iff (srst_in)
    ##1 irq_pin_out == ($past(source_level) ^ $past(int_pin_control_reg[C3_ACTIVE_LOW])))
    else $error("interrupt pin polarity wrong");
endmodule

// *** testbench/scr_host.sv ***
// Host model that reaches the register group with single-byte strobes.
`timescale 1ns/1ps
module scr_host (
  // Clock.
  input wire logic clock_in,
  // Register access.
  output logic [scr_pkg::ADDR_W-1:0] reg_addr_out,
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [scr_pkg::DATA_W-1:0] reg_wdata_out,
  input wire logic [scr_pkg::DATA_W-1:0] reg_rdata_in,
  input wire logic reg_hit_in
);
  import scr_pkg::*;
  initial begin
    reg_addr_out = 7'h00;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_wdata_out = 8'h00;
  end
  // Writes the byte exactly as asked, so the caller picks reserved bits and modes.
  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge clock_in);
    reg_addr_out = a;
    reg_wdata_out = d;
    reg_wr_out = 1'b1;
    @(negedge clock_in);
    reg_wr_out = 1'b0;
    reg_wdata_out = ~d;
  endtask
  task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                        output logic h);
    @(negedge clock_in);
    reg_addr_out = a;
    reg_rd_out = 1'b1;
    // Read data is taken at the edge that also applies the read side effects.
    @(posedge clock_in);
    d = reg_rdata_in;
    h = reg_hit_in;
    @(negedge clock_in);
    reg_rd_out = 1'b0;
  endtask
endmodule

// *** testbench/scr_regs_bench.sv ***
// Self-checking bench for the sensor register group.
`timescale 1ns/1ps
module scr_regs_bench;
  import scr_pkg::*;
  logic clock_in = 1'b0;
  logic srst_in = 1'b1;
  logic [ADDR_W-1:0] addr;
  logic wr, rd, hit, diff_on = 1'b0, odr = 1'b0, psmp = 1'b0, tsmp = 1'b0;
  logic qe = 1'b0, refld_seen = 1'b0;
  logic [RATE_W-1:0] rate = RATE_ONE_SHOT;
  logic [DATA_W-1:0] wdata, rdata;
  logic [PRESS_W-1:0] ref_p = 24'h000000, raw = 24'h000000, ref_val, press;
  logic start, trim, restart, refld, qon, lmon, dec, i2c_off, irq, irq_oe;
  int error_cnt = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #25 clock_in = ~clock_in;
  scr_host host (.clock_in(clock_in), .reg_addr_out(addr), .reg_wr_out(wr), .reg_rd_out(rd),
    .reg_wdata_out(wdata), .reg_rdata_in(rdata), .reg_hit_in(hit));
  scr_regs uut (.clock_in(clock_in), .srst_in(srst_in), .reg_addr_in(addr), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_hit_out(hit),
    .rate_sel_in(rate), .diff_circuit_on_in(diff_on), .threshold_in(16'h0001),
    .reference_in(ref_p), .odr_tick_in(odr), .press_sample_in(psmp), .temp_sample_in(tsmp),
    .press_raw_in(raw), .queue_empty_in(qe), .queue_level_mark_in(1'b0),
    .queue_full_in(1'b0), .measure_start_out(start), .trim_reload_out(trim),
    .device_restart_out(restart), .reference_load_out(refld), .reference_value_out(ref_val),
    .pressure_out(press), .queue_on_out(qon), .level_mark_on_out(lmon),
    .rate_decimate_1hz_out(dec), .i2c_off_out(i2c_off), .irq_pin_out(irq),
    .irq_pin_oe_out(irq_oe));
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      error_cnt++;
      test_done();
    end
  end
  // The reference capture is a one-cycle pulse, so it is remembered here.
  always @(posedge clock_in) begin
    if (refld) begin
      refld_seen <= 1'b1;
    end
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    logic [DATA_W-1:0] d;
    logic h;
    host.rd_reg(a, d, h);
    chk(24'(d), 24'(exp));
  endtask
  // One sample strobe; raw is scrambled afterwards so a late capture shows.
  task automatic smp(input logic p, input logic t, input logic [PRESS_W-1:0] r);
    @(negedge clock_in);
    psmp = p;
    tsmp = t;
    raw = r;
    @(negedge clock_in);
    psmp = 1'b0;
    tsmp = 1'b0;
    raw = ~r;
    @(negedge clock_in);
  endtask
  task automatic t_reset_and_masks();
    logic [DATA_W-1:0] d;
    logic h;
    logic [ADDR_W-1:0] ma [3] = '{7'h22, 7'h23, 7'h24};
    logic [DATA_W-1:0] mk [3] = '{8'hC3, 8'h0F, 8'h07};
    foreach (ma[i]) rchk(ma[i], 8'h00);
    rchk(7'h21, 8'h00);
    rchk(7'h25, 8'h00);
    rchk(7'h27, 8'h00);
    host.rd_reg(7'h26, d, h);
    chk({16'h0000, d}, 24'h000000);
    chk(24'(h), 24'h000000);
    foreach (ma[i]) begin
      host.wr_reg(ma[i], 8'hFF);
      rchk(ma[i], mk[i]);
      host.wr_reg(ma[i], 8'h00);
    end
    host.wr_reg(7'h25, 8'hFF);
    rchk(7'h25, 8'h00);
  endtask
  task automatic t_control();
    host.wr_reg(7'h21, 8'h78);
    chk(24'({qon, lmon, dec, i2c_off}), 24'h00000F);
    rchk(7'h21, 8'h78);
    host.wr_reg(7'h21, 8'h00);
    chk(24'({qon, lmon, dec, i2c_off}), 24'h000000);
  endtask
  task automatic t_status();
    host.wr_reg(7'h23, 8'h01);
    smp(1'b1, 1'b0, 24'h000010);
    chk(24'({irq, irq_oe}), 24'h000003);
    rchk(7'h27, 8'h02);
    smp(1'b1, 1'b0, 24'h000010);
    rchk(7'h27, 8'h22);
    rchk(7'h2A, 8'h00);
    rchk(7'h27, 8'h00);
    smp(1'b0, 1'b1, 24'h000000);
    smp(1'b0, 1'b1, 24'h000000);
    rchk(7'h27, 8'h11);
    rchk(7'h2C, 8'h00);
    rchk(7'h27, 8'h00);
    chk(24'({irq, irq_oe}), 24'h000001);
    host.wr_reg(7'h23, 8'h08);
    qe = 1'b1;
    @(negedge clock_in);
    chk(24'(irq), 24'h000001);
    qe = 1'b0;
    host.wr_reg(7'h23, 8'h00);
  endtask
  task automatic t_pressure();
    ref_p = 24'h000100;
    smp(1'b1, 1'b0, 24'h001234);
    chk(press, 24'h001134);
    rchk(7'h28, 8'h34);
    ref_p = 24'h000001;
    smp(1'b1, 1'b0, 24'h800000);
    chk(press, 24'h800000);
    ref_p = 24'h000000;
    host.wr_reg(7'h21, 8'h02);
    smp(1'b1, 1'b0, 24'h000345);
    chk(ref_val, 24'h000345);
    chk(press, 24'h000000);
    chk(24'(refld_seen), 24'h000001);
    host.wr_reg(7'h21, 8'h00);
  endtask
  task automatic t_diff();
    diff_on = 1'b1;
    host.wr_reg(7'h24, 8'h03);
    host.wr_reg(7'h22, 8'h41);
    smp(1'b1, 1'b0, 24'h000200);
    chk(24'({irq, irq_oe}), 24'h000003);
    rchk(7'h25, 8'h05);
    rchk(7'h25, 8'h00);
    chk(24'({irq, irq_oe}), 24'h000000);
    smp(1'b1, 1'b0, 24'hFFFE00);
    rchk(7'h25, 8'h06);
    diff_on = 1'b0;
    smp(1'b1, 1'b0, 24'h000200);
    rchk(7'h25, 8'h00);
    diff_on = 1'b1;
    host.wr_reg(7'h24, 8'h05);
    smp(1'b1, 1'b0, 24'h000200);
    smp(1'b1, 1'b0, 24'h000000);
    rchk(7'h25, 8'h05);
    rchk(7'h25, 8'h00);
    diff_on = 1'b0;
    host.wr_reg(7'h24, 8'h00);
  endtask
  task automatic t_boot();
    host.wr_reg(7'h22, 8'h80);
    @(negedge clock_in);
    chk(24'(irq), 24'h000001);
    host.wr_reg(7'h21, 8'h80);
    rchk(7'h21, 8'h80);
    @(negedge clock_in) odr = 1'b1;
    @(negedge clock_in) odr = 1'b0;
    for (int i = 0; i < 8 && trim !== 1'b1; i++) @(negedge clock_in);
    chk(24'(trim), 24'h000001);
    rchk(7'h21, 8'h00);
    host.wr_reg(7'h21, 8'h84);
    @(negedge clock_in) odr = 1'b1;
    @(negedge clock_in) odr = 1'b0;
    for (int i = 0; i < 8 && restart !== 1'b1; i++) @(negedge clock_in);
    chk(24'(restart), 24'h000001);
    rchk(7'h22, 8'h00);
    rchk(7'h21, 8'h00);
  endtask
  task automatic t_one_shot();
    rate = 3'h1;
    host.wr_reg(7'h21, 8'h01);
    repeat (3) begin
      @(negedge clock_in);
      chk(24'(start), 24'h000000);
    end
    rate = RATE_ONE_SHOT;
    for (int i = 0; i < 4 && start !== 1'b1; i++) @(negedge clock_in);
    chk(24'(start), 24'h000001);
    smp(1'b1, 1'b0, 24'h000000);
    rchk(7'h21, 8'h00);
  endtask
  initial begin
    repeat (6) @(negedge clock_in);
    srst_in = 1'b0;
    t_reset_and_masks();
    t_control();
    t_status();
    t_pressure();
    t_diff();
    t_boot();
    t_one_shot();
    test_done();
  end
endmodule
